// File: common/optical_ctrl_defines.vh
// Offsets, field positions, addresses and reset values of the optical module control block
`ifndef OPTICAL_CTRL_DEFINES_VH
`define OPTICAL_CTRL_DEFINES_VH

// ----------------------------------------------------------------------------
// Two-wire device addresses (8-bit form, write bit clear)
// ----------------------------------------------------------------------------
`define ID_DEV_ADDR          8'hA0
`define DIAG_DEV_ADDR        8'hA2

// ----------------------------------------------------------------------------
// Diagnostics page layout
// ----------------------------------------------------------------------------
`define LINE_CTRL_OFFSET     8'h6E
`define LCS_DIS_STATE_BIT    7
`define LCS_SOFT_DIS_BIT     6
`define LCS_FAULT_BIT        2
`define LCS_LOST_BIT         1
`define LCS_WRITE_MASK       8'h40
`define LCS_RESET            8'h00
`define MON_TEMP_OFFSET      8'h60
`define MON_VCC_OFFSET       8'h62
`define MON_BIAS_OFFSET      8'h64
`define MON_TXPWR_OFFSET     8'h66
`define MON_RXPWR_OFFSET     8'h68

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS        100
`define DIS_SPACING_MS       10

`endif

// File: rtl/twi_slave.v
// Byte-addressed two-wire slave answering at two device addresses
`timescale 1ns/1ns
`include "optical_ctrl_defines.vh"

module twi_slave
(
    // Clock and reset
    input  wire       clock,
    input  wire       nrst,
    // Two-wire pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    // Memory access
    output reg        page_sel,
    output reg  [7:0] mem_addr,
    input  wire [7:0] mem_rdata,
    output reg  [7:0] mem_wdata,
    output reg        mem_we
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_DEV   = 3'd1;
    localparam [2:0] S_WADDR = 3'd2;
    localparam [2:0] S_WDATA = 3'd3;
    localparam [2:0] S_RDATA = 3'd4;
    localparam [2:0] S_ACK   = 3'd5;
    localparam [2:0] S_MACK  = 3'd6;

    reg  [2:0] state_r;
    reg  [2:0] after_r;
    reg        scl_r;
    reg        sda_r;
    reg  [7:0] shift_r;
    reg  [3:0] cnt_r;
    reg        drive_r;

    wire scl_rise = scl_in & ~scl_r;
    wire scl_fall = ~scl_in & scl_r;
    wire start    = scl_in & scl_r & sda_r & ~sda_in;
    wire stop     = scl_in & scl_r & ~sda_r & sda_in;

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_r;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r   <= S_IDLE;
            after_r   <= S_IDLE;
            scl_r     <= 1'b1;
            sda_r     <= 1'b1;
            shift_r   <= 8'h00;
            cnt_r     <= 4'h0;
            drive_r   <= 1'b0;
            page_sel  <= 1'b0;
            mem_addr  <= 8'h00;
            mem_wdata <= 8'h00;
            mem_we    <= 1'b0;
        end
        else
        begin
            scl_r  <= scl_in;
            sda_r  <= sda_in;
            mem_we <= 1'b0;
            if (start)
            begin
                state_r <= S_DEV;
                cnt_r   <= 4'h0;
                drive_r <= 1'b0;
            end
            else if (stop)
            begin
                state_r <= S_IDLE;
                drive_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    S_IDLE:
                    begin
                        drive_r <= 1'b0;
                    end
                    S_DEV, S_WADDR, S_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_r <= {shift_r[6:0], sda_in};
                            cnt_r   <= cnt_r + 4'h1;
                        end
                        else if (scl_fall && cnt_r == 4'h8)
                        begin
                            cnt_r <= 4'h0;
                            if (state_r == S_DEV)
                            begin
                                if ({shift_r[7:1], 1'b0} == `ID_DEV_ADDR ||
                                    {shift_r[7:1], 1'b0} == `DIAG_DEV_ADDR)
                                begin
                                    page_sel  <= shift_r[1];
                                    drive_r   <= 1'b1;
                                    state_r   <= S_ACK;
                                    after_r   <= shift_r[0] ? S_RDATA : S_WADDR;
                                end
                                else
                                    state_r <= S_IDLE;
                            end
                            else if (state_r == S_WADDR)
                            begin
                                mem_addr <= shift_r;
                                drive_r  <= 1'b1;
                                state_r  <= S_ACK;
                                after_r  <= S_WDATA;
                            end
                            else
                            begin
                                mem_wdata <= shift_r;
                                mem_we    <= 1'b1;
                                drive_r   <= 1'b1;
                                state_r   <= S_ACK;
                                after_r   <= S_WDATA;
                            end
                        end
                    end
                    S_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state_r <= after_r;
                            cnt_r   <= 4'h0;
                            if (after_r == S_RDATA)
                            begin
                                shift_r <= mem_rdata;
                                drive_r <= ~mem_rdata[7];
                            end
                            else
                                drive_r <= 1'b0;
                        end
                    end
                    S_RDATA:
                    begin
                        if (scl_fall)
                        begin
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == 4'h7)
                            begin
                                drive_r  <= 1'b0;
                                mem_addr <= mem_addr + 8'h01;
                                state_r  <= S_MACK;
                            end
                            else
                            begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                drive_r <= ~shift_r[6];
                            end
                        end
                    end
                    S_MACK:
                    begin
                        // Host ack continues a sequential read, nack ends it
                        if (scl_rise)
                            state_r <= sda_in ? S_IDLE : S_ACK;
                        after_r <= S_RDATA;
                    end
                    default:
                        state_r <= S_IDLE;
                endcase
            end
            // Step past a byte only after its write strobe has used the address
            if (mem_we)
                mem_addr <= mem_addr + 8'h01;
        end
    end

endmodule // twi_slave

// File: rtl/optical_ctrl.v
// Control pins, status mirror and two-wire management memory of an optical module
`timescale 1ns/1ns
`include "optical_ctrl_defines.vh"
// Notes on behaviour
// - Retimers lock at top rate, bypassed otherwise
// - Separate transmit and receive rate selects
// - Transmit rate high engages transmit retimer
// - Shut-off input high turns transmitter off
// - Shut-off toggle clears the latched fault
// - Undriven shut-off input counts as asserted
// - Byte 110: soft shut-off bit6, status bit7
// - Transmitter off when soft or pin set
// - Identification page at address A0
// - Diagnostics page at second address
// - EEPROM style byte-addressed two-wire access
// - Diagnostics page shows live monitor readings
// - Shut-off and signal-lost mirrored into status
// - Laser fault latches, disables, mirrored bit2
// - Signal-lost output mirrored at bit1
// - Receive rate high engages receive retimer

module optical_ctrl
#(
    parameter ID_INIT_VALUE = 8'h00  // Arbitrary fill for the identification page
)
(
    // Clock and reset
    input  wire        clock,
    input  wire        nrst,
    // Rate selects and retimer controls
    input  wire        tx_rate_sel,
    input  wire        rx_rate_sel,
    output reg         tx_retime_en,
    output reg         rx_retime_en,
    // Transmit shut-off
    input  wire        tx_disable_in,
    input  wire        tx_disable_driven,
    output reg         laser_off,
    // Fault and signal loss
    input  wire        laser_fault_evt,
    output wire        tx_fault_out,
    output wire        tx_fault_oe,
    input  wire        receive_signal_lost,
    output reg         signal_lost_flag,
    // Monitor readings
    input  wire [15:0] mon_temp,
    input  wire [15:0] mon_vcc,
    input  wire [15:0] mon_bias,
    input  wire [15:0] mon_tx_power,
    input  wire [15:0] mon_rx_power,
    // Two-wire pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe
);

    // ------------------------------------------------------------------------
    // Rate selects
    // ------------------------------------------------------------------------
    // Retimers engage only at the top rate; each side follows its own select
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_retime_en <= 1'b0;
            rx_retime_en <= 1'b0;
        end
        else
        begin
            tx_retime_en <= tx_rate_sel;
            rx_retime_en <= rx_rate_sel;
        end
    end

    // ------------------------------------------------------------------------
    // Signal loss
    // ------------------------------------------------------------------------
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            signal_lost_flag <= 1'b0;
        else
            signal_lost_flag <= receive_signal_lost;
    end

    // ------------------------------------------------------------------------
    // Shut-off and fault
    // ------------------------------------------------------------------------
    reg        soft_dis_r;
    reg        fault_r;
    reg        dis_pin_r;
    reg        dis_seen_r;
    wire       dis_pin = tx_disable_in | ~tx_disable_driven;

    // Fault pin is open collector: pulled low when healthy, released on fault
    assign tx_fault_out = 1'b0;
    assign tx_fault_oe  = ~fault_r;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            dis_pin_r    <= 1'b1;
            dis_seen_r   <= 1'b0;
            fault_r      <= 1'b0;
            laser_off    <= 1'b1;
        end
        else
        begin
            dis_pin_r <= dis_pin;
            // A high then low on the pin clears the fault; a new fault wins
            if (laser_fault_evt)
            begin
                fault_r    <= 1'b1;
                dis_seen_r <= 1'b0;
            end
            else if (fault_r && dis_pin)
                dis_seen_r <= 1'b1;
            else if (fault_r && dis_seen_r && !dis_pin)
            begin
                fault_r    <= 1'b0;
                dis_seen_r <= 1'b0;
            end
            laser_off <= dis_pin | soft_dis_r | fault_r | laser_fault_evt;
        end
    end

    // ------------------------------------------------------------------------
    // Management memory
    // ------------------------------------------------------------------------
    wire       page_sel;
    wire [7:0] mem_addr;
    wire [7:0] mem_wdata;
    wire       mem_we;
    reg  [7:0] id_mem [0:255];
    reg  [7:0] diag_mem [0:255];
    reg  [7:0] rdata;
    reg  [7:0] lcs;
    integer    i;

    // ------------------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------------------
    always @*
    begin
        lcs = `LCS_RESET;
        lcs[`LCS_DIS_STATE_BIT] = dis_pin_r;
        lcs[`LCS_SOFT_DIS_BIT]  = soft_dis_r;
        lcs[`LCS_FAULT_BIT]     = fault_r;
        lcs[`LCS_LOST_BIT]      = signal_lost_flag;
    end

    // ------------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------------
    // Monitor words read most significant byte first, at the even offset
    always @*
    begin
        rdata = 8'h00;
        if (!page_sel)
            rdata = id_mem[mem_addr];
        else
        begin
            case (mem_addr)
                `LINE_CTRL_OFFSET:           rdata = lcs;
                `MON_TEMP_OFFSET:            rdata = mon_temp[15:8];
                `MON_TEMP_OFFSET + 8'h01:    rdata = mon_temp[7:0];
                `MON_VCC_OFFSET:             rdata = mon_vcc[15:8];
                `MON_VCC_OFFSET + 8'h01:     rdata = mon_vcc[7:0];
                `MON_BIAS_OFFSET:            rdata = mon_bias[15:8];
                `MON_BIAS_OFFSET + 8'h01:    rdata = mon_bias[7:0];
                `MON_TXPWR_OFFSET:           rdata = mon_tx_power[15:8];
                `MON_TXPWR_OFFSET + 8'h01:   rdata = mon_tx_power[7:0];
                `MON_RXPWR_OFFSET:           rdata = mon_rx_power[15:8];
                `MON_RXPWR_OFFSET + 8'h01:   rdata = mon_rx_power[7:0];
                default:                     rdata = diag_mem[mem_addr];
            endcase
        end
    end

    // Identification page is read-only; diagnostic scratch is writable
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
        begin
            id_mem[i]   = ID_INIT_VALUE;
            diag_mem[i] = 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Memory writes
    // ------------------------------------------------------------------------
    always @(posedge clock)
    begin
        if (mem_we && page_sel)
            diag_mem[mem_addr] <= mem_wdata;
    end

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            soft_dis_r <= 1'b0;
        else if (mem_we && page_sel && mem_addr == `LINE_CTRL_OFFSET)
            soft_dis_r <= mem_wdata[`LCS_SOFT_DIS_BIT];
    end

    // ------------------------------------------------------------------------
    // Two-wire slave
    // ------------------------------------------------------------------------
    twi_slave u_twi
    (
        .clock     (clock),
        .nrst      (nrst),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe),
        .page_sel  (page_sel),
        .mem_addr  (mem_addr),
        .mem_rdata (rdata),
        .mem_wdata (mem_wdata),
        .mem_we    (mem_we)
    );

endmodule // optical_ctrl

// File: bench/optical_ctrl_assertions.sv
// Port-level checker of the optical module control block
`timescale 1ns/1ns
module optical_ctrl_checker
(
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Watched ports
    input wire tx_rate_sel,
    input wire rx_rate_sel,
    input wire tx_retime_en,
    input wire rx_retime_en,
    input wire tx_disable_in,
    input wire tx_disable_driven,
    input wire laser_off,
    input wire laser_fault_evt,
    input wire tx_fault_oe,
    input wire receive_signal_lost,
    input wire signal_lost_flag,
    input wire sda_out,
    input wire sda_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // Registered copies still hold reset values for the first edge after release
    reg [1:0] up_r;
    always @(posedge clock or negedge nrst)
        if (!nrst)
            up_r <= 2'h0;
        else if (!up_r[1])
            up_r <= up_r + 2'h1;
    a_tx_retime_follow: assert property (
        up_r[1] |-> tx_retime_en == $past(tx_rate_sel))
        else $error("transmit retimer does not follow its rate select");
    a_rx_retime_follow: assert property (up_r[1] |-> rx_retime_en == $past(rx_rate_sel))
        else $error("receive retimer does not follow its rate select");
    a_pin_turns_off: assert property (
        up_r[1] && $past(tx_disable_in || !tx_disable_driven) |-> laser_off)
        else $error("transmitter on while shut-off pin asserted");
    a_fault_disables: assert property (laser_fault_evt |=> laser_off && !tx_fault_oe)
        else $error("laser fault not latched");
    a_fault_holds: assert property (
        (!tx_fault_oe && !tx_disable_in && tx_disable_driven)[*3] |=> !tx_fault_oe)
        else $error("fault cleared without a shut-off toggle");
    a_toggle_clears: assert property (
        $past(tx_disable_in && tx_disable_driven) && !tx_disable_in && tx_disable_driven
        && !laser_fault_evt |-> ##[0:3] tx_fault_oe)
        else $error("shut-off toggle did not clear the fault");
    a_lost_follow: assert property (
        up_r[1] |-> signal_lost_flag == $past(receive_signal_lost))
        else $error("signal lost output does not follow its input");
    a_sda_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    a_reset_safe: assert property (
        disable iff (1'b0) !nrst |-> laser_off && !sda_oe && tx_fault_oe)
        else $error("unsafe outputs during reset");
    c_fault: cover property (laser_fault_evt);
    c_ack: cover property ($rose(sda_oe));
    c_float: cover property (!tx_disable_driven && laser_off);
endmodule // optical_ctrl_checker

// File: bench/twi_host.sv
// Two-wire host model driving the clock line and pulling the data line low
`timescale 1ns/1ns
module twi_host
(
    // Clock
    input  wire clock,
    // Two-wire lines
    input  wire sda_line,
    output reg  scl,
    output reg  sda_oe
);
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // Slow phases so the clocked slave samples each level several times
    task half;
        repeat (4) @(posedge clock);
    endtask
    // Also serves as repeated start from a low clock line
    task start;
        sda_oe <= 1'b0;
        half;
        scl <= 1'b1;
        half;
        sda_oe <= 1'b1;
        half;
        scl <= 1'b0;
        half;
    endtask
    task stop;
        sda_oe <= 1'b1;
        half;
        scl <= 1'b1;
        half;
        sda_oe <= 1'b0;
        half;
    endtask
    // Data changes only while the clock line is low
    task bitx(input b, output r);
        sda_oe <= ~b;
        half;
        scl <= 1'b1;
        half;
        r = sda_line;
        scl <= 1'b0;
        half;
    endtask
    // Eight bits out or in, then the acknowledge slot carrying rel
    task xfer(input [7:0] d, input rel, output [7:0] q, output ack);
        reg r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(rel, r);
        ack = ~r;
    endtask
endmodule // twi_host

// File: bench/testbench.sv
// Self-checking bench of the optical module control block
`timescale 1ns/1ns
`include "optical_ctrl_defines.vh"
module testbench;
    localparam [7:0] ID_FILL = 8'h5A;  // Arbitrary identification fill
    reg         clock = 1'b0;
    reg         nrst = 1'b1;
    reg         tx_rate_sel = 1'b0;
    reg         rx_rate_sel = 1'b0;
    reg         tx_disable_in = 1'b1;
    reg         tx_disable_driven = 1'b1;
    reg         laser_fault_evt = 1'b0;
    reg         receive_signal_lost = 1'b0;
    reg  [79:0] mv = {16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h0F1E};
    wire        tx_retime_en, rx_retime_en, laser_off, tx_fault_oe, signal_lost_flag;
    wire        tx_fault_out;
    wire [3:0]  pins_out = {tx_retime_en, rx_retime_en, laser_off, signal_lost_flag};
    wire        scl, host_oe, sda_out, sda_oe;
    wire        sda_line = ~(host_oe | sda_oe);
    reg  [7:0]  rdata [0:9];
    reg  [16:0] rows [0:3];
    reg         a;
    int         fail_count = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    initial
        forever #50 clock = ~clock;
    twi_host host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_oe(host_oe));
    optical_ctrl #(.ID_INIT_VALUE(ID_FILL)) dut (.clock(clock), .nrst(nrst),
        .tx_rate_sel(tx_rate_sel), .rx_rate_sel(rx_rate_sel), .tx_retime_en(tx_retime_en),
        .rx_retime_en(rx_retime_en), .tx_disable_in(tx_disable_in),
        .tx_disable_driven(tx_disable_driven), .laser_off(laser_off),
        .laser_fault_evt(laser_fault_evt), .tx_fault_out(tx_fault_out),
        .tx_fault_oe(tx_fault_oe),
        .receive_signal_lost(receive_signal_lost), .signal_lost_flag(signal_lost_flag),
        .mon_temp(mv[79:64]), .mon_vcc(mv[63:48]), .mon_bias(mv[47:32]),
        .mon_tx_power(mv[31:16]), .mon_rx_power(mv[15:0]), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe));
    task finish_test;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] dev, input [7:0] off, input [7:0] d, output ack);
        reg [7:0] q;
        reg       x;
        host.start;
        host.xfer(dev, 1'b1, q, ack);
        host.xfer(off, 1'b1, q, x);
        host.xfer(d, 1'b1, q, x);
        host.stop;
    endtask
    // Sequential read after a repeated start, last byte not acknowledged
    task rd(input [7:0] dev, input [7:0] off, input int n);
        reg [7:0] q;
        reg       x;
        host.start;
        host.xfer(dev, 1'b1, q, x);
        host.xfer(off, 1'b1, q, x);
        host.start;
        host.xfer(dev | 8'h01, 1'b1, q, x);
        for (int i = 0; i < n; i++)
            host.xfer(8'hFF, i == n - 1, rdata[i], x);
        host.stop;
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            fail_count++;
            finish_test;
        end
    end
    initial
    begin
        // Reset falls after the design's processes wait on it, so it is seen
        nrst <= 1'b0;
        // Inputs {tx rate, rx rate, pin, driven, lost}, outputs, status byte
        rows[0] = {5'h1A, 4'hC, 8'h00};
        rows[1] = {5'h17, 4'hB, 8'h82};
        rows[2] = {5'h08, 4'h6, 8'h80};
        rows[3] = {5'h03, 4'h1, 8'h02};
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 4; i++)
        begin
            {tx_rate_sel, rx_rate_sel, tx_disable_in, tx_disable_driven,
                receive_signal_lost} <= rows[i][16:12];
            repeat (3) @(posedge clock);
            @(negedge clock);
            chk(pins_out, rows[i][11:8]);
            rd(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 1);
            chk(rdata[0], rows[i][7:0]);
        end
        receive_signal_lost <= 1'b0;
        wr(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 8'hFF, a);
        chk(a, 1'b1);
        rd(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 1);
        chk(rdata[0], 8'h40);
        chk(laser_off, 1'b1);
        wr(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 8'h00, a);
        @(negedge clock);
        chk(laser_off, 1'b0);
        @(posedge clock);
        laser_fault_evt <= 1'b1;
        @(posedge clock);
        laser_fault_evt <= 1'b0;
        repeat (4) @(negedge clock);
        chk({laser_off, tx_fault_oe}, 2'h2);
        chk(tx_fault_out, 1'b0);
        rd(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 1);
        chk(rdata[0], 8'h04);
        chk({laser_off, tx_fault_oe}, 2'h2);
        @(posedge clock);
        // Host side: assertion gap is shortened, the block keeps no timer for it
        tx_disable_in <= 1'b1;
        repeat (5) @(posedge clock);
        tx_disable_in <= 1'b0;
        repeat (5) @(negedge clock);
        chk({laser_off, tx_fault_oe}, 2'h1);
        rd(`DIAG_DEV_ADDR, `MON_TEMP_OFFSET, 10);
        for (int i = 0; i < 10; i++)
            chk(rdata[i], mv[79 - 8 * i -: 8]);
        wr(`ID_DEV_ADDR, 8'h00, 8'h33, a);
        chk(a, 1'b1);
        rd(`ID_DEV_ADDR, 8'h00, 1);
        chk(rdata[0], ID_FILL);
        wr(8'hA4, `LINE_CTRL_OFFSET, 8'h40, a);
        chk(a, 1'b0);
        wr(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 8'h40, a);
        {tx_rate_sel, rx_rate_sel} <= 2'h3;
        nrst <= 1'b0;
        repeat (2) @(negedge clock);
        chk({laser_off, tx_retime_en, rx_retime_en, tx_fault_oe, sda_oe}, 5'h12);
        @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        rd(`DIAG_DEV_ADDR, `LINE_CTRL_OFFSET, 1);
        chk(rdata[0], `LCS_RESET);
        finish_test;
    end
endmodule // testbench
bind optical_ctrl optical_ctrl_checker u_chk (.clock(clock), .nrst(nrst),
    .tx_rate_sel(tx_rate_sel), .rx_rate_sel(rx_rate_sel), .tx_retime_en(tx_retime_en),
    .rx_retime_en(rx_retime_en), .tx_disable_in(tx_disable_in),
    .tx_disable_driven(tx_disable_driven), .laser_off(laser_off),
    .laser_fault_evt(laser_fault_evt), .tx_fault_oe(tx_fault_oe),
    .receive_signal_lost(receive_signal_lost), .signal_lost_flag(signal_lost_flag),
    .sda_out(sda_out), .sda_oe(sda_oe));
